// ==== rtl/pdo_debug_bus.sv ====
// transaction layer debug observation bus with register slave
//
// Summary of operation
// - Five data link error flags, packet error lowest, protocol error highest.
// - Nine transaction layer error flags, poisoned packet lowest, malformed top.
// - Channel 0 four status bits: to cfg, from cfg, not empty, credits.
// - Channel 1 same four status bits on the next four output bits.
// - Channels 2 and 3 same four status bits on their own ranges.
// - Upper output fields come from the channel named by the select field.
// - Receive descriptor machine shown as three-bit code, idle to wait.
// - Bypass-valid bit high while bypass holds for the current packet.
// - Receive payload machine shown as two-bit code, idle to last.
// - Reorder-busy bit high while the reordering queue is working.
// - Receive FIFO empty bit high while the packet FIFO holds nothing.
// - Pending bit high between FIFO extraction and application delivery.
// - Transmit machine shown as four-bit code, idle to second config.
// - Receive credits as six packed fields, pd and cpld fields twelve bits.
// - Transmit credits in the same six-field packing at the top.
// - Non-posted data credits held to eight bits in both reports.
`timescale 1ns/1ns
module pdo_debug_bus (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [31:0] test_in,
   input wire logic [4:0] dll_err_in,
   input wire logic [8:0] trn_err_in,
   input wire logic [15:0] vc_status_in,
   input wire logic [11:0] receive_descriptor_fsm_code,
   input wire logic [3:0] bypass_valid_in,
   input wire logic [7:0] receive_payload_fsm_code,
   input wire logic [3:0] reorder_queue_active,
   input wire logic [3:0] rx_fifo_empty_in,
   input wire logic [3:0] rx_pending_in,
   input wire logic [15:0] transmit_fsm_code,
   input wire logic [31:0] rx_cred_ph_in,
   input wire logic [47:0] rx_cred_pd_in,
   input wire logic [31:0] rx_cred_nph_in,
   input wire logic [31:0] rx_cred_npd_in,
   input wire logic [31:0] rx_cred_cplh_in,
   input wire logic [47:0] rx_cred_cpld_in,
   input wire logic [31:0] tx_cred_ph_in,
   input wire logic [47:0] tx_cred_pd_in,
   input wire logic [31:0] tx_cred_nph_in,
   input wire logic [31:0] tx_cred_npd_in,
   input wire logic [31:0] tx_cred_cplh_in,
   input wire logic [47:0] tx_cred_cpld_in,
   output logic [255:0] test_out,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq
);

   logic [255:0] test_out_reg;
   logic [255:0] test_out_next;
   logic [2:0] sel;
   logic [1:0] vc;
   logic vc_ok;
   logic rsv_seen;
   logic [14:0] status_reg;
   logic [14:0] status_next;
   logic [14:0] mask_reg;
   logic [14:0] events;
   logic [14:0] clr_bits;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic irq_reg;
   logic accept;

   // pack one credit report; npd is only eight bits wide on purpose
   function automatic logic [55:0] pack_cred(
      input logic [7:0] ph,
      input logic [11:0] pd,
      input logic [7:0] nph,
      input logic [7:0] npd,
      input logic [7:0] cplh,
      input logic [11:0] cpld
   );
      logic [55:0] r;
      r = '0;
      r[pdo_pkg::PH_LSB +: pdo_pkg::HDR_W] = ph;
      r[pdo_pkg::PD_LSB +: pdo_pkg::DAT_W] = pd;
      r[pdo_pkg::NPH_LSB +: pdo_pkg::HDR_W] = nph;
      r[pdo_pkg::NPD_LSB +: pdo_pkg::NPD_W] = npd;
      r[pdo_pkg::CPLH_LSB +: pdo_pkg::HDR_W] = cplh;
      r[pdo_pkg::CPLD_LSB +: pdo_pkg::DAT_W] = cpld;
      return r;
   endfunction

   // channel select decode; codes beyond the last channel read as zero
   assign sel = test_in[pdo_pkg::SEL_LSB +: pdo_pkg::SEL_W];
   assign vc = sel[1:0];
   assign vc_ok = (sel < 3'(pdo_pkg::NUM_VC));

   // observation bus contents; inputs are only read, never steered
   always_comb begin
      test_out_next = '0;
      test_out_next[pdo_pkg::DLL_ERR_LSB +: pdo_pkg::DLL_ERR_W] =
         dll_err_in;
      test_out_next[pdo_pkg::TRN_ERR_LSB +: pdo_pkg::TRN_ERR_W] =
         trn_err_in;
      // four channels of four status bits each, channel 0 lowest
      test_out_next[pdo_pkg::VC_STAT_LSB +: 16] = vc_status_in;
      if (vc_ok) begin
         test_out_next[pdo_pkg::RXDESC_LSB +: pdo_pkg::RXDESC_W] =
            receive_descriptor_fsm_code[vc*3 +: 3];
         test_out_next[pdo_pkg::BYPASS_BIT] = bypass_valid_in[vc];
         test_out_next[pdo_pkg::RXPAY_LSB +: pdo_pkg::RXPAY_W] =
            receive_payload_fsm_code[vc*2 +: 2];
         test_out_next[pdo_pkg::REORDER_BIT] =
            reorder_queue_active[vc];
         test_out_next[pdo_pkg::FIFO_EMPTY_BIT] = rx_fifo_empty_in[vc];
         test_out_next[pdo_pkg::PENDING_BIT] = rx_pending_in[vc];
         test_out_next[pdo_pkg::TXFSM_LSB +: pdo_pkg::TXFSM_W] =
            transmit_fsm_code[vc*4 +: 4];
         test_out_next[pdo_pkg::RXCRED_LSB +: pdo_pkg::CRED_W] = pack_cred(
            rx_cred_ph_in[vc*8 +: 8], rx_cred_pd_in[vc*12 +: 12],
            rx_cred_nph_in[vc*8 +: 8], rx_cred_npd_in[vc*8 +: 8],
            rx_cred_cplh_in[vc*8 +: 8],
            rx_cred_cpld_in[vc*12 +: 12]);
         test_out_next[pdo_pkg::TXCRED_LSB +: pdo_pkg::CRED_W] = pack_cred(
            tx_cred_ph_in[vc*8 +: 8], tx_cred_pd_in[vc*12 +: 12],
            tx_cred_nph_in[vc*8 +: 8], tx_cred_npd_in[vc*8 +: 8],
            tx_cred_cplh_in[vc*8 +: 8],
            tx_cred_cpld_in[vc*12 +: 12]);
      end
   end

   // reserved machine codes on the selected channel, flagged for software
   always_comb begin
      rsv_seen = 1'b0;
      if (vc_ok) begin
         rsv_seen = (receive_descriptor_fsm_code[vc*3 +: 3] >
                     pdo_pkg::PDO_DESC_WAIT) ||
                    (transmit_fsm_code[vc*4 +: 4] > pdo_pkg::PDO_TX_CFG1);
      end
   end

   // one register stage so the bus leaves on clean flop outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         test_out_reg <= '0;
      end else if (clk_en) begin
         test_out_reg <= test_out_next;
      end
   end

   // avalon handshake: waitrequest drops for one cycle per request
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wait_reg <= 1'b1;
      end else if (clk_en) begin
         if (wait_reg && (avs_read || avs_write)) begin
            wait_reg <= 1'b0;
         end else begin
            wait_reg <= 1'b1;
         end
      end
   end

   assign accept = !wait_reg && (avs_read || avs_write);

   // read data mux; unmapped addresses answer zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (avs_address)
         pdo_pkg::REG_STATUS: rdata_next[14:0] = status_reg;
         pdo_pkg::REG_MASK: rdata_next[14:0] = mask_reg;
         pdo_pkg::REG_SEL_STATE: begin
            rdata_next[15:13] = sel;
            rdata_next[12:0] = test_out_reg[pdo_pkg::CHAN_LSB +: 13];
         end
         pdo_pkg::REG_VC_STATUS:
            rdata_next[15:0] = test_out_reg[pdo_pkg::VC_STAT_LSB +: 16];
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // read data captured while waitrequest is still high, stands at accept
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         if (wait_reg && avs_read) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // mask register, byte lanes 0 and 1 only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mask_reg <= pdo_pkg::MASK_RST;
      end else if (clk_en) begin
         if (accept && avs_write && avs_address == pdo_pkg::REG_MASK) begin
            if (avs_byteenable[0]) begin
               mask_reg[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
               mask_reg[14:8] <= avs_writedata[14:8];
            end
         end
      end
   end

   // sticky status; only bits actually reported are cleared, set wins
   assign events = {rsv_seen, trn_err_in, dll_err_in};
   always_comb begin
      clr_bits = '0;
      if (accept && avs_read && avs_address == pdo_pkg::REG_STATUS) begin
         clr_bits = rdata_reg[14:0];
      end
      status_next = (status_reg & ~clr_bits) | events;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_reg <= pdo_pkg::STATUS_RST;
      end else if (clk_en) begin
         status_reg <= status_next;
      end
   end

   // level interrupt, one cycle behind status so it leaves a flop
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else if (clk_en) begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   assign test_out = test_out_reg;
   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign irq = irq_reg;

   // channel 0 views for the checks below
   logic [2:0] ast_desc0;
   logic [1:0] ast_pay0;
   logic [3:0] ast_tx0;
   logic [7:0] ast_npd0;
   logic [11:0] ast_cpld0;
   assign ast_desc0 = receive_descriptor_fsm_code[2:0];
   assign ast_pay0 = receive_payload_fsm_code[1:0];
   assign ast_tx0 = transmit_fsm_code[3:0];
   assign ast_npd0 = tx_cred_npd_in[7:0];
   assign ast_cpld0 = rx_cred_cpld_in[11:0];

   // reset is sampled here, so a check never starts on the release edge
   logic ast_run;
   assign ast_run = clk_en && !sys_rst;

   default clocking ast_clk @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence seq_req_seen;
      clk_en && wait_reg && (avs_read || avs_write);
   endsequence
   sequence seq_one_low;
      !wait_reg ##1 wait_reg;
   endsequence

   AST_DLL_ERR: assert property (
      ast_run |=> test_out[89:85] == $past(dll_err_in))
      else $error("dll error flags not mirrored");
   AST_TRN_ERR: assert property (
      ast_run |=> test_out[98:90] == $past(trn_err_in))
      else $error("trn error flags not mirrored");
   AST_VC_STATUS: assert property (
      ast_run |=> test_out[114:99] == $past(vc_status_in))
      else $error("channel status bits misplaced");
   AST_SEL_OFF: assert property (
      ast_run && test_in[31:29] >= 3'h4 |=> test_out[255:131] == '0)
      else $error("out of range channel not zero");
   AST_DESC0: assert property (
      ast_run && test_in[31:29] == 3'h0 |=> test_out[133:131] ==
      $past(ast_desc0))
      else $error("descriptor code wrong for channel 0");
   AST_BYPASS3: assert property (
      ast_run && test_in[31:29] == 3'h3 |=> test_out[134] ==
      $past(bypass_valid_in[3]))
      else $error("bypass valid wrong for channel 3");
   AST_PAY0: assert property (
      ast_run && test_in[31:29] == 3'h0 |=> test_out[136:135] ==
      $past(ast_pay0))
      else $error("payload code wrong for channel 0");
   AST_REORDER2: assert property (
      ast_run && test_in[31:29] == 3'h2 |=> test_out[137] ==
      $past(reorder_queue_active[2]))
      else $error("reorder busy wrong for channel 2");
   AST_EMPTY1: assert property (
      ast_run && test_in[31:29] == 3'h1 |=> test_out[138] ==
      $past(rx_fifo_empty_in[1]))
      else $error("fifo empty wrong for channel 1");
   AST_PEND3: assert property (
      ast_run && test_in[31:29] == 3'h3 |=> test_out[139] ==
      $past(rx_pending_in[3]))
      else $error("pending bit wrong for channel 3");
   AST_TX0: assert property (
      ast_run && test_in[31:29] == 3'h0 |=> test_out[143:140] ==
      $past(ast_tx0))
      else $error("transmit code wrong for channel 0");
   AST_RXCPLD0: assert property (
      ast_run && test_in[31:29] == 3'h0 |=> test_out[199:188] ==
      $past(ast_cpld0))
      else $error("receive cpld credits misplaced");
   AST_RXPH1: assert property (
      ast_run && test_in[31:29] == 3'h1 |=> test_out[151:144] ==
      $past(rx_cred_ph_in[15:8]))
      else $error("receive ph credits wrong for channel 1");
   AST_RXNPH0: assert property (
      ast_run && test_in[31:29] == 3'h0 |=> test_out[171:164] ==
      $past(rx_cred_nph_in[7:0]))
      else $error("receive nph credits wrong for channel 0");
   AST_RXNPD3: assert property (
      ast_run && test_in[31:29] == 3'h3 |=> test_out[179:172] ==
      $past(rx_cred_npd_in[31:24]))
      else $error("receive npd credits wrong for channel 3");
   AST_TXPD2: assert property (
      ast_run && test_in[31:29] == 3'h2 |=> test_out[219:208] ==
      $past(tx_cred_pd_in[35:24]))
      else $error("transmit pd credits wrong for channel 2");
   AST_TXCPLH1: assert property (
      ast_run && test_in[31:29] == 3'h1 |=> test_out[243:236] ==
      $past(tx_cred_cplh_in[15:8]))
      else $error("transmit cplh credits wrong for channel 1");
   AST_TXNPD0: assert property (
      ast_run && test_in[31:29] == 3'h0 |=> test_out[235:228] ==
      $past(ast_npd0))
      else $error("transmit npd credits misplaced");
   AST_STICKY: assert property (
      ast_run && dll_err_in[0] |=> status_reg[0])
      else $error("error event not latched");
   AST_IRQ_LEVEL: assert property (
      ast_run |=> irq == |($past(status_reg) & $past(mask_reg)))
      else $error("interrupt not following masked status");
   AST_RD_CLEAR: assert property (
      ast_run && accept && avs_read && avs_address == pdo_pkg::REG_STATUS
      |=> (status_reg & $past(rdata_reg[14:0]) & ~$past(events)) ==
      15'h0000)
      else $error("status bits survived the read that returned them");
   AST_BUS_ANSWER: assert property (
      seq_req_seen |=> seq_one_low)
      else $error("waitrequest not low for exactly one cycle");
endmodule

// ==== rtl/pdo_pkg.sv ====
// constants for the transaction layer debug observation bus
package pdo_pkg;
   // channel select field of the test input
   localparam int NUM_VC = 4;
   localparam int SEL_LSB = 29;
   localparam int SEL_W = 3;
   // test output field positions and widths
   localparam int TOUT_W = 256;
   localparam int DLL_ERR_LSB = 85;
   localparam int DLL_ERR_W = 5;
   localparam int TRN_ERR_LSB = 90;
   localparam int TRN_ERR_W = 9;
   localparam int VC_STAT_LSB = 99;
   localparam int VC_STAT_W = 4;
   localparam int CHAN_LSB = 131;
   localparam int RXDESC_LSB = 131;
   localparam int RXDESC_W = 3;
   localparam int BYPASS_BIT = 134;
   localparam int RXPAY_LSB = 135;
   localparam int RXPAY_W = 2;
   localparam int REORDER_BIT = 137;
   localparam int FIFO_EMPTY_BIT = 138;
   localparam int PENDING_BIT = 139;
   localparam int TXFSM_LSB = 140;
   localparam int TXFSM_W = 4;
   localparam int RXCRED_LSB = 144;
   localparam int TXCRED_LSB = 200;
   localparam int CRED_W = 56;
   // credit field layout inside one 56-bit report
   localparam int PH_LSB = 0;
   localparam int HDR_W = 8;
   localparam int PD_LSB = 8;
   localparam int DAT_W = 12;
   localparam int NPH_LSB = 20;
   localparam int NPD_LSB = 28;
   localparam int NPD_W = 8;
   localparam int CPLH_LSB = 36;
   localparam int CPLD_LSB = 44;
   // state machine encodings
   typedef enum logic [2:0] {
      PDO_DESC_IDLE = 3'h0, PDO_DESC_PH0 = 3'h1, PDO_DESC_PH1 = 3'h2,
      PDO_DESC_PH2 = 3'h3, PDO_DESC_WAIT = 3'h4
   } pdo_desc_t;
   typedef enum logic [3:0] {
      PDO_TX_IDLE = 4'h0, PDO_TX_DESC4 = 4'h1, PDO_TX_DESC3_NORM = 4'h2,
      PDO_TX_DESC3_SHFT = 4'h3, PDO_TX_DATA_NORM = 4'h4,
      PDO_TX_DATA_SHFT = 4'h5, PDO_TX_DATA_LAST = 4'h6,
      PDO_TX_CFG0 = 4'h7, PDO_TX_CFG1 = 4'h8
   } pdo_tx_t;
   // register map, byte addresses
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_SEL_STATE = 4'h8;
   localparam logic [3:0] REG_VC_STATUS = 4'hc;
   localparam int STATUS_W = 15;
   localparam int RSV_BIT = 14;
   localparam logic [14:0] MASK_RST = 15'h0000;
   localparam logic [14:0] STATUS_RST = 15'h0000;
endpackage

// ==== tb/pdo_probe_model.sv ====
// debug-side probe: selects a channel, lets it settle, takes a snapshot
`timescale 1ns/1ns
module pdo_probe_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sel_go,
   input wire logic [2:0] sel_req,
   input wire logic [255:0] test_out,
   output logic [31:0] test_in,
   output logic [124:0] snap,
   output logic done
);
   logic [1:0] wait_reg;
   // select held still; snapshot only once the mux output has settled
   always @(posedge clock) begin
      if (sys_rst) begin
         test_in <= 32'h0;
         wait_reg <= 2'h0;
         done <= 1'b0;
         snap <= '0;
      end else if (sel_go) begin
         test_in[31:29] <= sel_req;
         wait_reg <= 2'h3;
         done <= 1'b0;
      end else if (wait_reg != 2'h0) begin
         wait_reg <= wait_reg - 2'h1;
         if (wait_reg == 2'h1) begin
            snap <= test_out[255:131];
            done <= 1'b1;
         end
      end
   end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the debug observation bus
`timescale 1ns/1ns
module tb;
   typedef struct packed {
      logic [2:0] sel;
      logic [4:0] dll;
      logic [8:0] trn;
      logic [15:0] vc;
      logic [3:0] flg;
      logic [7:0] ph;
   } pdo_tb_row_t;
   // flg: bypass, reorder, empty, pending from bit 0 up
   pdo_tb_row_t rows [10] = '{
      '{3'h4, 5'h01, 9'h000, 16'hffff, 4'hf, 8'h00},
      '{3'h0, 5'h02, 9'h001, 16'h0001, 4'h1, 8'h01},
      '{3'h1, 5'h04, 9'h002, 16'h0010, 4'h2, 8'h80},
      '{3'h2, 5'h08, 9'h004, 16'h0100, 4'h4, 8'hff},
      '{3'h3, 5'h10, 9'h008, 16'h1000, 4'h8, 8'h7e},
      '{3'h0, 5'h00, 9'h010, 16'h8421, 4'h5, 8'h3c},
      '{3'h1, 5'h00, 9'h020, 16'h1234, 4'ha, 8'hc3},
      '{3'h2, 5'h00, 9'h040, 16'hedcb, 4'h3, 8'h55},
      '{3'h3, 5'h00, 9'h080, 16'h0f0f, 4'hc, 8'haa},
      '{3'h0, 5'h00, 9'h100, 16'hf0f0, 4'h0, 8'h11}};
   logic clock, sys_rst, clk_en, sel_go, done, irq;
   logic avs_read, avs_write, avs_waitrequest;
   logic [2:0] sel_req;
   logic [3:0] bypass_valid_in, reorder_queue_active, rx_fifo_empty_in;
   logic [3:0] rx_pending_in, avs_address, avs_byteenable;
   logic [4:0] dll_err_in;
   logic [8:0] trn_err_in;
   logic [7:0] receive_payload_fsm_code;
   logic [11:0] receive_descriptor_fsm_code;
   logic [15:0] vc_status_in, transmit_fsm_code;
   logic [31:0] test_in, avs_writedata, avs_readdata, rd;
   logic [31:0] rx_cred_ph_in, rx_cred_nph_in, rx_cred_npd_in, rx_cred_cplh_in;
   logic [31:0] tx_cred_ph_in, tx_cred_nph_in, tx_cred_npd_in, tx_cred_cplh_in;
   logic [47:0] rx_cred_pd_in, rx_cred_cpld_in, tx_cred_pd_in, tx_cred_cpld_in;
   logic [124:0] snap, hx;
   logic [255:0] test_out;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   pdo_debug_bus uut (
      .clock(clock),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .test_in(test_in),
      .dll_err_in(dll_err_in),
      .trn_err_in(trn_err_in),
      .vc_status_in(vc_status_in),
      .receive_descriptor_fsm_code(receive_descriptor_fsm_code),
      .bypass_valid_in(bypass_valid_in),
      .receive_payload_fsm_code(receive_payload_fsm_code),
      .reorder_queue_active(reorder_queue_active),
      .rx_fifo_empty_in(rx_fifo_empty_in),
      .rx_pending_in(rx_pending_in),
      .transmit_fsm_code(transmit_fsm_code),
      .rx_cred_ph_in(rx_cred_ph_in),
      .rx_cred_pd_in(rx_cred_pd_in),
      .rx_cred_nph_in(rx_cred_nph_in),
      .rx_cred_npd_in(rx_cred_npd_in),
      .rx_cred_cplh_in(rx_cred_cplh_in),
      .rx_cred_cpld_in(rx_cred_cpld_in),
      .tx_cred_ph_in(tx_cred_ph_in),
      .tx_cred_pd_in(tx_cred_pd_in),
      .tx_cred_nph_in(tx_cred_nph_in),
      .tx_cred_npd_in(tx_cred_npd_in),
      .tx_cred_cplh_in(tx_cred_cplh_in),
      .tx_cred_cpld_in(tx_cred_cpld_in),
      .test_out(test_out),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .irq(irq)
   );
   pdo_probe_model probe (
      .clock(clock),
      .sys_rst(sys_rst),
      .sel_go(sel_go),
      .sel_req(sel_req),
      .test_out(test_out),
      .test_in(test_in),
      .snap(snap),
      .done(done)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // hang guard, far above the roughly 120 cycles the run needs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic conclude;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one bus cycle; ends an edge after release so strobes never double up
   task automatic bus(input logic w, input logic [3:0] a,
         input logic [31:0] wd);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !w;
      avs_write <= w;
      // waitrequest and read data are both taken at the same rising edge
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // packs one credit report from a seed byte, each field a different mix of it
   function automatic logic [55:0] cred(input logic [7:0] b);
      return {b, b[7:4], b ^ 8'h3c, b + 8'h01, ~b, b[3:0], b, b};
   endfunction
   function automatic logic [124:0] hi_exp(input int i);
      int k = (i == 0) ? 0 : i - 1;
      if (rows[i].sel > 3'h3) return '0;
      return {cred(rows[i].ph ^ 8'ha5), cred(rows[i].ph), 4'(k),
         rows[i].flg[3:1], 2'(k % 4), rows[i].flg[0], 3'(k % 5)};
   endfunction
   // selected channel gets the row, the others legal but different values
   task automatic apply(input int i);
      pdo_tb_row_t r = rows[i];
      int k = (i == 0) ? 0 : i - 1;
      logic hit;
      logic [55:0] wr, wt;
      dll_err_in <= r.dll;
      trn_err_in <= r.trn;
      vc_status_in <= r.vc;
      sel_req <= r.sel;
      for (int c = 0; c < 4; c++) begin
         hit = (c == int'(r.sel));
         wr = cred(hit ? r.ph : ~r.ph);
         wt = cred((hit ? r.ph : ~r.ph) ^ 8'ha5);
         receive_descriptor_fsm_code[c*3+:3] <= 3'((k + !hit) % 5);
         receive_payload_fsm_code[c*2+:2] <= 2'(k + !hit);
         transmit_fsm_code[c*4+:4] <= 4'((k + !hit) % 9);
         bypass_valid_in[c] <= r.flg[0] ^ !hit;
         reorder_queue_active[c] <= r.flg[1] ^ !hit;
         rx_fifo_empty_in[c] <= r.flg[2] ^ !hit;
         rx_pending_in[c] <= r.flg[3] ^ !hit;
         {rx_cred_cpld_in[c*12+:12], rx_cred_cplh_in[c*8+:8]} <= wr[55:36];
         {rx_cred_npd_in[c*8+:8], rx_cred_nph_in[c*8+:8]} <= wr[35:20];
         {rx_cred_pd_in[c*12+:12], rx_cred_ph_in[c*8+:8]} <= wr[19:0];
         {tx_cred_cpld_in[c*12+:12], tx_cred_cplh_in[c*8+:8]} <= wt[55:36];
         {tx_cred_npd_in[c*8+:8], tx_cred_nph_in[c*8+:8]} <= wt[35:20];
         {tx_cred_pd_in[c*12+:12], tx_cred_ph_in[c*8+:8]} <= wt[19:0];
      end
   endtask

   initial begin
      {sys_rst, clk_en, avs_byteenable} = 6'h3f;
      {sel_go, sel_req, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {dll_err_in, trn_err_in, vc_status_in, bypass_valid_in} = '0;
      {receive_descriptor_fsm_code, receive_payload_fsm_code} = '0;
      {reorder_queue_active, rx_fifo_empty_in, rx_pending_in} = '0;
      {transmit_fsm_code, rx_cred_ph_in, rx_cred_pd_in} = '0;
      {rx_cred_nph_in, rx_cred_npd_in, rx_cred_cplh_in, rx_cred_cpld_in} = '0;
      {tx_cred_ph_in, tx_cred_pd_in, tx_cred_nph_in} = '0;
      {tx_cred_npd_in, tx_cred_cplh_in, tx_cred_cpld_in} = '0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk({test_out, avs_waitrequest, irq}, {256'h0, 2'h2});
      @(posedge clock);
      // table of channel selections and field patterns
      for (int i = 0; i < 10; i++) begin
         apply(i);
         sel_go <= 1'b1;
         @(posedge clock);
         sel_go <= 1'b0;
         // let the probe drop the done of the previous row first
         @(negedge clock);
         for (int n = 0; n < 20 && done !== 1'b1; n++) @(negedge clock);
         chk(done, 1'b1);
         chk(snap, hi_exp(i));
         chk(test_out[114:85],
            {rows[i].vc, rows[i].trn, rows[i].dll});
         chk({test_out[130:115], test_out[84:0]}, '0);
         @(posedge clock);
      end
      // sticky status, mask and interrupt
      @(negedge clock);
      chk(irq, 1'b0);
      @(posedge clock);
      bus(1'b1, pdo_pkg::REG_MASK, 32'h0000_0001);
      @(negedge clock);
      chk(irq, 1'b1);
      @(posedge clock);
      rd_chk(pdo_pkg::REG_MASK, 32'h1);
      dll_err_in <= 5'h0;
      trn_err_in <= 9'h0;
      repeat (2) @(posedge clock);
      rd_chk(pdo_pkg::REG_STATUS, 32'h3fff);
      rd_chk(pdo_pkg::REG_STATUS, 32'h0);
      @(negedge clock);
      chk(irq, 1'b0);
      @(posedge clock);
      bus(1'b1, pdo_pkg::REG_STATUS, 32'hffff_ffff);
      rd_chk(pdo_pkg::REG_STATUS, 32'h0);
      rd_chk(4'h2, 32'h0);
      hx = hi_exp(9);
      rd_chk(pdo_pkg::REG_SEL_STATE, {16'h0, rows[9].sel, hx[12:0]});
      rd_chk(pdo_pkg::REG_VC_STATUS, {16'h0, rows[9].vc});
      // reserved descriptor code is shown unchanged and flagged
      receive_descriptor_fsm_code[2:0] <= 3'h5;
      repeat (2) @(negedge clock);
      chk(test_out[133:131], 3'h5);
      @(posedge clock);
      rd_chk(pdo_pkg::REG_STATUS, 32'h4000);
      // clock enable low must freeze the bus outputs
      clk_en <= 1'b0;
      dll_err_in <= 5'h1f;
      repeat (3) @(negedge clock);
      chk(test_out[89:85], 5'h0);
      @(posedge clock);
      clk_en <= 1'b1;
      repeat (2) @(negedge clock);
      chk(test_out[89:85], 5'h1f);
      @(posedge clock);
      // only lane 1 enabled: the low mask byte must keep its value
      avs_byteenable <= 4'h2;
      bus(1'b1, pdo_pkg::REG_MASK, 32'h0000_7f7f);
      avs_byteenable <= 4'hf;
      rd_chk(pdo_pkg::REG_MASK, 32'h7f01);
      // second reset in mid-run
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk({test_out, irq}, 257'h0);
      @(posedge clock);
      rd_chk(pdo_pkg::REG_MASK, 32'h0);
      conclude();
   end
endmodule
